// ==== common/tws_pkg.sv ====
// Constants for the timer / watchdog block with a shared prescaler.
// Assumes one instruction cycle per clk edge; CPU strobes are synchronous.
// Functional notes
// - One 8-bit counter serves timer or watchdog
// - Only one user of the counter at once
// - Option bits 3:0 pick owner and ratio
// - Timer write clears prescaler when timer owns
// - Watchdog clear clears prescaler when watchdog owns
// - Prescaler count not readable or writable
// - Every reset zeroes the prescaler count
// - Owner may change on any option write
// - Timer at 01h, kept across resets
// - Clock source select forces pin to input
// - Watchdog runs only when enable fuse set
// - Ratio field sets the owner's division, timer or watchdog
// - Edge select picks falling or rising edges
// - Option write-only, loaded by option instruction
// - Reset sets all option bits to one
package tws_pkg;

  // ----------------------------------------------------------------
  // Addresses and layout
  // ----------------------------------------------------------------
  localparam logic [4:0] TIMER_ADDR     = 5'h01;
  localparam int         OPT_PS_LSB     = 0;
  localparam int         OPT_PS_MSB     = 2;
  localparam int         OPT_ASSIGN_BIT = 3;
  localparam int         OPT_EDGE_BIT   = 4;
  localparam int         OPT_SRC_BIT    = 5;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] OPTION_RESET   = 8'hFF;
  localparam logic [7:0] PRESC_RESET    = 8'h00;

  // ----------------------------------------------------------------
  // Clock period and cycle counts
  // ----------------------------------------------------------------
  localparam int         CLK_PERIOD_NS  = 50;
  localparam logic [1:0] WRITE_HOLD_CYC = 2'h2;
  // Last base count; the base watchdog period before postscaling is 4096 clk cycles
  localparam logic [11:0] WDT_BASE_MAX  = 12'hFFF;

endpackage

// ==== hdl/tws_edge_sync.sv ====
// Pin synchroniser with rising and falling edge detect.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/1ps
module tws_edge_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Pin and edges
  input  wire logic pin_async,
  output logic      rise,
  output logic      fall
);

  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= pin_async;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // Only the second stage and later feed the detectors
  assign rise = sync_reg & ~prev_reg;
  assign fall = ~sync_reg & prev_reg;

endmodule

// ==== hdl/tws_timer_top.sv ====
// Timer with an 8-bit prescaler shared with the watchdog.
// Assumes clk is the instruction clock and all CPU strobes are
// one-cycle pulses synchronous to it; the pin is asynchronous.
`timescale 1ns/1ps
module tws_timer_top (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // File register write from the core
  input  wire logic       wr_en,
  input  wire logic [4:0] wr_addr,
  input  wire logic [7:0] wr_data,
  // File register read from the core
  input  wire logic       rd_en,
  input  wire logic [4:0] rd_addr,
  output logic      [7:0] rd_data,
  // Option instruction and watchdog clear instruction
  input  wire logic       option_wr,
  input  wire logic [7:0] option_data,
  input  wire logic       watchdog_clear_instr,
  // Configuration
  input  wire logic       watchdog_enable_fuse,
  // Shared pin
  input  wire logic       timer_external_clock_pin,
  input  wire logic       pin_direction_ctl,
  input  wire logic       pin_out_data,
  output logic            pin_out,
  output logic            pin_oe_n,
  // Status
  output logic      [7:0] timer_count,
  output logic      [7:0] option_value,
  output logic            watchdog_timeout
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_sync_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Ratio decode
  // ----------------------------------------------------------------
  // True when the low n bits of cnt are all ones; n = 0 always hits
  function automatic logic tws_hit(input logic [7:0] cnt, input logic [3:0] n);
    logic [7:0] mask;
    mask = 8'hFF >> (4'h8 - n);
    return &(cnt | ~mask);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] option_config_reg;
  logic [7:0] presc_reg;
  logic [7:0] presc_next;
  logic [7:0] timer_count_reg;
  logic [7:0] timer_next;
  logic [1:0] hold_reg;
  logic [1:0] hold_next;
  logic [7:0] rd_data_reg;
  logic       pin_out_reg;
  logic       pin_oe_n_reg;
  logic       timeout_reg;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic       assign_wdt;
  logic       src_ext;
  logic       edge_fall;
  logic [2:0] ratio;
  logic       timer_wr;
  logic       ext_rise;
  logic       ext_fall;
  logic       src_evt;
  logic       base_tick;
  logic       presc_tick;
  logic       timer_inc;
  logic       post_tick;
  logic       wdt_clr_presc;

  assign assign_wdt = option_config_reg[tws_pkg::OPT_ASSIGN_BIT];
  assign src_ext    = option_config_reg[tws_pkg::OPT_SRC_BIT];
  assign edge_fall  = option_config_reg[tws_pkg::OPT_EDGE_BIT];
  assign ratio      = option_config_reg[tws_pkg::OPT_PS_MSB:tws_pkg::OPT_PS_LSB];
  assign timer_wr   = wr_en && (wr_addr == tws_pkg::TIMER_ADDR);

  tws_edge_sync u_edge (
    .clk       (clk),
    .rst_n     (rst_sync_reg),
    .pin_async (timer_external_clock_pin),
    .rise      (ext_rise),
    .fall      (ext_fall)
  );

  tws_watchdog u_wdt (
    .clk       (clk),
    .rst_n     (rst_sync_reg),
    .enable    (watchdog_enable_fuse),
    .clear     (watchdog_clear_instr),
    .base_tick (base_tick)
  );

  // Internal source counts every instruction cycle
  assign src_evt = src_ext ? (edge_fall ? ext_fall : ext_rise) : 1'b1;

  // Counter input follows its current owner only
  assign presc_tick = assign_wdt ? base_tick : src_evt;

  // Timer owner divides by 2^(ratio+1); watchdog owner bypasses it
  assign timer_inc = assign_wdt ? src_evt
                   : src_evt && tws_hit(presc_reg, {1'b0, ratio} + 4'h1);

  // Watchdog owner divides by 2^ratio; timer owner leaves ticks raw
  assign post_tick = assign_wdt ? base_tick && tws_hit(presc_reg, {1'b0, ratio})
                   : base_tick;

  assign wdt_clr_presc = watchdog_clear_instr && assign_wdt;

  // Clear wins over a same-cycle increment
  assign presc_next = (timer_wr && !assign_wdt) ? tws_pkg::PRESC_RESET
                    : wdt_clr_presc ? tws_pkg::PRESC_RESET
                    : presc_tick ? presc_reg + 8'h01
                    : presc_reg;

  assign hold_next = timer_wr ? tws_pkg::WRITE_HOLD_CYC
                   : (hold_reg != 2'h0) ? hold_reg - 2'h1
                   : hold_reg;

  // Wraps 255 to 0 by plain 8-bit overflow
  assign timer_next = timer_wr ? wr_data
                    : (timer_inc && hold_reg == 2'h0) ? timer_count_reg + 8'h01
                    : timer_count_reg;

  // ----------------------------------------------------------------
  // Option register
  // ----------------------------------------------------------------
  // Write-only; no read path exists, the copy on option_value feeds
  // the pull-up and wake logic outside this block
  always_ff @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      option_config_reg <= tws_pkg::OPTION_RESET;
    end else if (option_wr) begin
      option_config_reg <= option_data;
    end
  end

  // ----------------------------------------------------------------
  // Prescaler and hold
  // ----------------------------------------------------------------
  // No port reads or loads the count directly
  always_ff @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      presc_reg <= tws_pkg::PRESC_RESET;
      hold_reg  <= 2'h0;
    end else begin
      presc_reg <= presc_next;
      hold_reg  <= hold_next;
    end
  end

  // ----------------------------------------------------------------
  // Timer count
  // ----------------------------------------------------------------
  // No reset: value survives device resets and is unknown at power-up
  always_ff @(posedge clk) begin
    timer_count_reg <= timer_next;
  end

  // ----------------------------------------------------------------
  // Read port, pin and timeout
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      rd_data_reg  <= 8'h00;
      pin_out_reg  <= 1'b0;
      pin_oe_n_reg <= 1'b1;
      timeout_reg  <= 1'b0;
    end else begin
      if (rd_en) begin
        rd_data_reg <= (rd_addr == tws_pkg::TIMER_ADDR) ? timer_count_reg : 8'h00;
      end
      pin_out_reg  <= pin_out_data;
      pin_oe_n_reg <= src_ext ? 1'b1 : pin_direction_ctl;
      timeout_reg  <= watchdog_enable_fuse && post_tick;
    end
  end

  assign rd_data          = rd_data_reg;
  assign pin_out          = pin_out_reg;
  assign pin_oe_n         = pin_oe_n_reg;
  assign timer_count      = timer_count_reg;
  assign option_value     = option_config_reg;
  assign watchdog_timeout = timeout_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_reg);

  a_presc_timer_clear: assert property (
    timer_wr && !assign_wdt |=> presc_reg == 8'h00)
    else $error("prescaler not cleared by timer write");

  a_presc_wdt_clear: assert property (
    watchdog_clear_instr && assign_wdt && !timer_wr |=> presc_reg == 8'h00 && !watchdog_timeout)
    else $error("prescaler not cleared by watchdog clear");

  a_presc_keep_other: assert property (
    watchdog_clear_instr && !assign_wdt && !timer_wr
      |=> presc_reg == $past(presc_reg) + {7'h00, $past(src_evt)})
    else $error("watchdog clear touched timer prescaler");

  a_timer_hold_two: assert property (
    timer_wr ##1 !timer_wr [*2] |-> timer_count_reg == $past(wr_data, 2))
    else $error("timer moved during write hold");

  a_timer_direct_inc: assert property (
    assign_wdt && src_evt && !timer_wr && hold_reg == 2'h0 && !option_wr
      |=> timer_count_reg == $past(timer_count_reg) + 8'h01)
    else $error("timer missed direct increment");

  a_timer_div_two: assert property (
    !assign_wdt && !src_ext && ratio == 3'h0 && hold_reg == 2'h0 && !timer_wr
      && !option_wr && presc_reg[0] |=> timer_count_reg == $past(timer_count_reg) + 8'h01)
    else $error("timer ratio 1:2 wrong");

  a_option_reset: assert property (
    $rose(rst_sync_reg) |-> option_value == 8'hFF && presc_reg == 8'h00)
    else $error("option or prescaler reset value wrong");

  a_option_load: assert property (
    option_wr |=> assign_wdt == $past(option_data[3]) && ratio == $past(option_data[2:0]))
    else $error("option write not applied");

  a_pin_input_force: assert property (
    src_ext && !option_wr |=> pin_oe_n)
    else $error("pin driven while external clock selected");

  a_wdt_disabled: assert property (
    !watchdog_enable_fuse |=> !watchdog_timeout)
    else $error("timeout while watchdog disabled");

  a_timer_write_load: assert property (
    timer_wr |=> timer_count_reg == $past(wr_data))
    else $error("timer write not loaded");

  a_hold_load: assert property (
    timer_wr |=> hold_reg == tws_pkg::WRITE_HOLD_CYC)
    else $error("write hold not started");

  a_rd_timer_data: assert property (
    rd_en && rd_addr == tws_pkg::TIMER_ADDR |=> rd_data == $past(timer_count_reg))
    else $error("timer read data wrong");

  a_rd_other_zero: assert property (
    rd_en && rd_addr != tws_pkg::TIMER_ADDR |=> rd_data == 8'h00)
    else $error("read of other address not zero");

  // Watchdog owner: prescaler moves only on watchdog ticks or a watchdog clear
  a_presc_wdt_count: assert property (
    assign_wdt && base_tick |=> presc_reg == $past(presc_reg) + 8'h01)
    else $error("postscaler missed a watchdog tick");

  a_presc_wdt_idle: assert property (
    assign_wdt && !base_tick && !watchdog_clear_instr |=> $stable(presc_reg))
    else $error("postscaler moved without a watchdog tick");

  a_wdt_ratio_one: assert property (
    assign_wdt && ratio == 3'h0 && base_tick |=> watchdog_timeout)
    else $error("watchdog ratio 1:1 wrong");

  a_timer_owner_wdt: assert property (
    !assign_wdt && base_tick |=> watchdog_timeout)
    else $error("unscaled watchdog tick lost");

  a_pin_follow_dir: assert property (
    !src_ext |=> pin_oe_n == $past(pin_direction_ctl))
    else $error("pin enable ignores direction bit");

  a_edge_wrong_skip: assert property (
    src_ext && !timer_wr && (edge_fall ? ext_rise : ext_fall) |=> $stable(timer_count_reg))
    else $error("timer counted the unselected edge");

  c_timer_wrap: cover property (timer_count_reg == 8'hFF ##1 timer_count_reg == 8'h00);
  c_wdt_timeout: cover property (watchdog_timeout);
  c_assign_switch: cover property (assign_wdt ##1 !assign_wdt);
  c_ext_edge: cover property (src_ext && src_evt && timer_inc);
  c_wdt_post_div: cover property (assign_wdt && ratio == 3'h1 && watchdog_timeout);

endmodule

// ==== hdl/tws_watchdog.sv ====
// Watchdog base counter, free running while enabled.
// Assumes clear is a one-cycle strobe from the instruction decoder.
`timescale 1ns/1ps
module tws_watchdog (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control
  input  wire logic enable,
  input  wire logic clear,
  // Base period tick
  output logic      base_tick
);

  logic [11:0] base_reg;
  logic [11:0] base_next;

  // Disabled watchdog holds at zero so no tick escapes
  assign base_next = (!enable || clear || base_reg == tws_pkg::WDT_BASE_MAX) ? 12'h000
                   : base_reg + 12'h001;
  assign base_tick = enable && !clear && (base_reg == tws_pkg::WDT_BASE_MAX);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      base_reg <= 12'h000;
    end else begin
      base_reg <= base_next;
    end
  end

endmodule

// ==== testbench/timer_wdt_shared_prescaler_tb_top.sv ====
// Bench for the timer with shared prescaler: model, stimulus and checks.
// Assumes tws_cpu_model drives every instruction strobe of the core.
`timescale 1ns/1ps
module timer_wdt_shared_prescaler_tb_top;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        fuse = 1'b1;
  logic        pin = 1'b0;
  logic        dir = 1'b0;
  logic        pod = 1'b0;
  logic        wr_en, rd_en, option_wr, wd_clr, pin_out, pin_oe_n, wd_to;
  logic [4:0]  wr_addr, rd_addr;
  logic [7:0]  wr_data, option_data, rd_data, timer_count, option_value;
  logic [31:0] seed = 32'h4D3A;
  int          n_fail = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          m, n, t0;

  always #25 clk = ~clk;
  // Ceiling well above the roughly 30000 cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 45000) begin
      n_fail++;
      conclude();
    end
  end

  tws_cpu_model cpu (.clk(clk), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_en(rd_en), .rd_addr(rd_addr), .option_wr(option_wr), .option_data(option_data),
    .watchdog_clear_instr(wd_clr));
  tws_timer_top dut (.clk(clk), .rstn(rstn), .wr_en(wr_en), .wr_addr(wr_addr),
    .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
    .option_wr(option_wr), .option_data(option_data), .watchdog_clear_instr(wd_clr),
    .watchdog_enable_fuse(fuse), .timer_external_clock_pin(pin),
    .pin_direction_ctl(dir), .pin_out_data(pod), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .timer_count(timer_count), .option_value(option_value),
    .watchdog_timeout(wd_to));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc_n(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic wait_tc(input int lim);
    logic [7:0] v;
    v = timer_count;
    n = 0;
    while (timer_count === v && n < lim) begin
      cyc_n(1);
      n++;
    end
  endtask

  // Clear, then count cycles to the timeout pulse; 9000 means none seen
  task automatic wd_check(input int lo, input int hi);
    n = 0;
    cpu.issue(3, 5'h00, 8'h00);
    while (wd_to !== 1'b1 && n < 9000) begin
      cyc_n(1);
      n++;
    end
    chk("wd_period", (n >= lo && n <= hi) ? 16'(n) : 16'(lo), 16'(n));
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    cyc_n(4);
    chk("opt_reset", 16'h00FF, 16'(option_value));
    chk("oe_reset", 16'h0001, 16'(pin_oe_n));
    chk("rd_reset", 16'h0000, 16'(rd_data));
    rstn = 1'b1;
    cyc_n(2);
    for (int ps = 0; ps < 8; ps++) begin
      seed = lfsr(seed);
      dir = seed[0];
      pod = seed[1];
      cpu.to_timer({5'h00, 3'(ps)});
      cpu.issue(0, 5'h01, 8'h00);
      chk("pin_oe_n", 16'(dir), 16'(pin_oe_n));
      chk("pin_out", 16'(pod), 16'(pin_out));
      wait_tc(600);
      wait_tc(600);
      chk("tmr_period", 16'(1 << (ps + 1)), 16'(n));
    end
    cyc_n(100);
    t0 = cyc;
    cpu.issue(0, 5'h01, 8'h00);
    wait_tc(600);
    n = cyc - t0;
    chk("clr_delay", 16'd258, 16'(n));
    $display("test prescaler ratios done");
    cpu.to_watchdog(8'h08);
    seed = lfsr(seed);
    m = 250 + seed[2:0];
    cpu.issue(0, 5'h01, 8'(m));
    for (int i = 0; i < 12; i++) begin
      if (i >= 3) m++;
      chk("timer", 16'(m & 255), 16'(timer_count));
      cyc_n(1);
    end
    wd_check(4090, 4100);
    cpu.issue(2, 5'h00, 8'h09);
    wd_check(8180, 8200);
    $display("test watchdog postscaler done");
    dir = 1'b0;
    cpu.issue(2, 5'h00, 8'h28);
    seed = lfsr(seed);
    m = seed[7:0];
    cpu.issue(0, 5'h01, 8'(m));
    chk("pin_oe_n", 16'h0001, 16'(pin_oe_n));
    for (int e = 0; e < 2; e++) begin
      if (e == 1) cpu.issue(2, 5'h00, 8'h38);
      repeat (3) begin
        pin = 1'b1;
        cyc_n(6);
        if (e == 0) m++;
        chk("timer_rise", 16'(m & 255), 16'(timer_count));
        pin = 1'b0;
        cyc_n(6);
        if (e == 1) m++;
        chk("timer_fall", 16'(m & 255), 16'(timer_count));
      end
    end
    cpu.issue(0, 5'h02, 8'h5A);
    cpu.issue(1, 5'h01, 8'h00);
    chk("rd_timer", 16'(m & 255), 16'(rd_data));
    cpu.issue(1, 5'h07, 8'h00);
    chk("rd_other", 16'h0000, 16'(rd_data));
    rstn = 1'b0;
    cyc_n(4);
    chk("opt_reset", 16'h00FF, 16'(option_value));
    chk("timer_kept", 16'(m & 255), 16'(timer_count));
    rstn = 1'b1;
    cyc_n(3);
    $display("test pin edges and reset done");
    cpu.to_timer(8'h00);
    wd_check(4090, 4100);
    fuse = 1'b0;
    wd_check(9000, 9000);
    $display("test watchdog enable done");
    conclude();
  end
endmodule

// ==== testbench/tws_cpu_model.sv ====
// Core model issuing timer, option and watchdog clear instructions.
// Assumes the bench calls its tasks; strobes move 1 ns after clk rises.
`timescale 1ns/1ps
module tws_cpu_model (
  // Clock
  input  wire logic clk,
  // Instruction strobes
  output logic       wr_en,
  output logic [4:0] wr_addr,
  output logic [7:0] wr_data,
  output logic       rd_en,
  output logic [4:0] rd_addr,
  output logic       option_wr,
  output logic [7:0] option_data,
  output logic       watchdog_clear_instr
);
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    option_wr = 1'b0;
    watchdog_clear_instr = 1'b0;
    wr_addr = 5'h00;
    rd_addr = 5'h00;
    wr_data = 8'h00;
    option_data = 8'h00;
  end

  // Kind 0 write, 1 read, 2 option, 3 watchdog clear; held over the taking edge
  task automatic issue(input int k, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    wr_addr = a;
    rd_addr = a;
    wr_data = d;
    option_data = d;
    wr_en = (k == 0);
    rd_en = (k == 1);
    option_wr = (k == 2);
    watchdog_clear_instr = (k == 3);
    @(posedge clk);
    #1;
    {wr_en, rd_en, option_wr, watchdog_clear_instr} = 4'h0;
    // Released data lines stop showing the last value
    wr_data = ~wr_data;
    option_data = ~option_data;
  endtask

  task automatic to_watchdog(input logic [7:0] opt);
    issue(3, 5'h00, 8'h00);
    issue(0, 5'h01, 8'h00);
    if (opt[2:1] == 2'h0) begin
      issue(2, 5'h00, {opt[7:4], 4'hF});
      issue(3, 5'h00, 8'h00);
    end
    issue(2, 5'h00, opt);
  endtask

  task automatic to_timer(input logic [7:0] opt);
    issue(3, 5'h00, 8'h00);
    issue(2, 5'h00, opt);
  endtask
endmodule
